// ==== jtag_debugger_model.sv ====
// Model of the external debugger driving the serial test port.
`timescale 1ns/100ps
module jtag_debugger_model
  import watchpoint_pkg::*;
(
  // Clock
  input wire logic clk,
  // TAP pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // ****************************************************************
  // Test clock and frames
  // ****************************************************************
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // One 800 ns test clock; it stays low between frames.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(posedge clk);
    #1 q = tdo;
    tck = 1'h1;
    repeat (4) @(posedge clk);
    #1 tck = 1'h0;
  endtask
  // Full data scan: data field first in and first out, flag bit last in bit 37.
  task automatic scan(input logic [37:0] din, output logic [37:0] dout);
    logic q;
    step(1'h0, ~tdi, q);
    step(1'h1, ~tdi, q);
    step(1'h0, ~tdi, q);
    step(1'h0, ~tdi, q);
    for (int i = 0; i < 38; i++) begin
      step(i == 37, din[i], q);
      dout[i] = q;
    end
    step(1'h1, ~tdi, q);
    step(1'h0, ~tdi, q);
  endtask
endmodule

// ==== watchpoint_comparator_unit.sv ====
// Top of the two-unit watchpoint comparator with its scan chain.
`timescale 1ns/100ps
`include "watchpoint_regs.svh"
module watchpoint_comparator_unit
  import watchpoint_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // TAP pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic debug_tap_reset_n,
  output logic tdo,
  // Core bus
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busData,
  input wire logic busValid,
  input wire logic busWrite,
  input wire logic [1:0] busSize,
  input wire logic fetch_or_data_bit,
  input wire logic privilege_bit,
  input wire logic [1:0] external_condition_in,
  // Exception events
  input wire logic prefetchAbort,
  input wire logic dataAbort,
  input wire logic irqPending,
  input wire logic debugExit,
  // Break and debug state
  output logic break_request,
  output logic debugState,
  output logic interruptsDisabled,
  output logic irqRemembered,
  output logic abortRemembered,
  output logic abortModeEntry,
  output logic linked_match_out,
  output logic range_couple_out
);
  // ****************************************************************
  // Pin synchronisers and TCK edge detection
  // ****************************************************************
  logic [1:0] tckSync_reg, tmsSync_reg, tdiSync_reg, trstSync_reg;
  logic tckLast_reg;
  logic tckRise, tckFall, tapResetHeld;

  always_ff @(posedge clk) begin
    if (reset) begin
      tckSync_reg <= 2'h0;
    end else begin
      tckSync_reg <= {tckSync_reg[0], tck};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tmsSync_reg <= 2'h0;
    end else begin
      tmsSync_reg <= {tmsSync_reg[0], tms};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tdiSync_reg <= 2'h0;
    end else begin
      tdiSync_reg <= {tdiSync_reg[0], tdi};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trstSync_reg <= 2'h0;
    end else begin
      trstSync_reg <= {trstSync_reg[0], debug_tap_reset_n};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tckLast_reg <= 1'b0;
    end else begin
      tckLast_reg <= tckSync_reg[1];
    end
  end

  assign tckRise = tckSync_reg[1] && !tckLast_reg;
  assign tckFall = !tckSync_reg[1] && tckLast_reg;
  assign tapResetHeld = !trstSync_reg[1];

  // ****************************************************************
  // TAP state machine
  // ****************************************************************
  tap_state_e tap_reg, tap_next;

  always_comb begin
    case (tap_reg)
      TAP_RESET: tap_next = tmsSync_reg[1] ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = tmsSync_reg[1] ? TAP_SELDR : TAP_IDLE;
      TAP_SELDR: tap_next = tmsSync_reg[1] ? TAP_SELIR : TAP_CAPDR;
      TAP_CAPDR: tap_next = tmsSync_reg[1] ? TAP_EX1DR : TAP_SHDR;
      TAP_SHDR: tap_next = tmsSync_reg[1] ? TAP_EX1DR : TAP_SHDR;
      TAP_EX1DR: tap_next = tmsSync_reg[1] ? TAP_UPDDR : TAP_PAUSEDR;
      TAP_PAUSEDR: tap_next = tmsSync_reg[1] ? TAP_EX2DR : TAP_PAUSEDR;
      TAP_EX2DR: tap_next = tmsSync_reg[1] ? TAP_UPDDR : TAP_SHDR;
      TAP_UPDDR: tap_next = tmsSync_reg[1] ? TAP_SELDR : TAP_IDLE;
      TAP_SELIR: tap_next = tmsSync_reg[1] ? TAP_RESET : TAP_CAPIR;
      TAP_CAPIR: tap_next = tmsSync_reg[1] ? TAP_EX1IR : TAP_SHIR;
      TAP_SHIR: tap_next = tmsSync_reg[1] ? TAP_EX1IR : TAP_SHIR;
      TAP_EX1IR: tap_next = tmsSync_reg[1] ? TAP_UPDIR : TAP_PAUSEIR;
      TAP_PAUSEIR: tap_next = tmsSync_reg[1] ? TAP_EX2IR : TAP_PAUSEIR;
      TAP_EX2IR: tap_next = tmsSync_reg[1] ? TAP_UPDIR : TAP_SHIR;
      TAP_UPDIR: tap_next = tmsSync_reg[1] ? TAP_SELDR : TAP_IDLE;
      default: tap_next = TAP_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset || tapResetHeld) begin
      tap_reg <= TAP_RESET;
    end else if (tckRise) begin
      tap_reg <= tap_next;
    end
  end

  // ****************************************************************
  // 38-bit scan chain
  // ****************************************************************
  logic [`WP_CHAIN_LEN-1:0] chain_reg;
  logic updatePulse_reg;
  logic [31:0] rdata0, rdata1, readMux;
  logic [4:0] chainAddr;
  logic chainRw, unitSel, inRange;
  logic [2:0] regSel;

  assign chainAddr = chain_reg[`WP_ADDR_MSB:`WP_ADDR_LSB];
  assign chainRw = chain_reg[`WP_RW_BIT];
  assign unitSel = chainAddr[3];
  assign regSel = chainAddr[2:0];
  assign inRange = chainAddr[4] &&
    (regSel <= 3'(`WP_CTRL_MSK - `WP_ADDR_VAL));
  assign readMux = unitSel ? rdata1 : rdata0;

  // Shift LSB first on TCK rise; read data lands on the following update.
  always_ff @(posedge clk) begin
    if (reset || tapResetHeld) begin
      chain_reg <= '0;
    end else if (tckRise && tap_reg == TAP_SHDR) begin
      chain_reg <= {tdiSync_reg[1], chain_reg[`WP_CHAIN_LEN-1:1]};
    end else if (updatePulse_reg && !chainRw && inRange) begin
      chain_reg[`WP_DATA_MSB:`WP_DATA_LSB] <= readMux;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || tapResetHeld) begin
      updatePulse_reg <= 1'b0;
    end else begin
      updatePulse_reg <= tckRise && tap_next == TAP_UPDDR &&
        tap_reg != TAP_UPDDR;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tdo <= 1'b0;
    end else if (tckFall) begin
      tdo <= chain_reg[0];
    end
  end

  // ****************************************************************
  // Comparator units
  // ****************************************************************
  logic wr0, wr1, hit0, hit1, link1, rng1;
  logic [8:0] ctrl0, ctrl1;

  assign wr0 = updatePulse_reg && chainRw && inRange && !unitSel;
  assign wr1 = updatePulse_reg && chainRw && inRange && unitSel;
  // Observed control word in control-register layout.
  assign ctrl1 = {1'b0, 1'b0, 1'b0, external_condition_in[1],
    privilege_bit, fetch_or_data_bit,
    busSize, busWrite};
  assign ctrl0 = {1'b0, rng1, link1, external_condition_in[0],
    privilege_bit, fetch_or_data_bit, busSize, busWrite};

  watchpoint_unit unit0 (
    .clk(clk),
    .reset(reset),
    .tapResetHeld(tapResetHeld),
    .regWrite(wr0),
    .regSel(regSel),
    .regWdata(chain_reg[`WP_DATA_MSB:`WP_DATA_LSB]),
    .regRdata(rdata0),
    .busAddr(busAddr),
    .busData(busData),
    .busValid(busValid),
    .busCtrl(ctrl0),
    .matchPulse(hit0),
    .linkedMatchOut(),
    .rangeCoupleOut()
  );

  watchpoint_unit unit1 (
    .clk(clk),
    .reset(reset),
    .tapResetHeld(tapResetHeld),
    .regWrite(wr1),
    .regSel(regSel),
    .regWdata(chain_reg[`WP_DATA_MSB:`WP_DATA_LSB]),
    .regRdata(rdata1),
    .busAddr(busAddr),
    .busData(busData),
    .busValid(busValid),
    .busCtrl(ctrl1),
    .matchPulse(hit1),
    .linkedMatchOut(link1),
    .rangeCoupleOut(rng1)
  );

  // ****************************************************************
  // Debug entry priority
  // ****************************************************************
  logic anyHit, fetchHit, enterDebug;

  assign anyHit = hit0 || hit1;
  assign fetchHit = anyHit && !fetch_or_data_bit;
  assign enterDebug = !debugState && anyHit &&
    !(fetchHit && prefetchAbort);

  always_ff @(posedge clk) begin
    if (reset) begin
      break_request <= 1'b0;
    end else begin
      break_request <= enterDebug;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      linked_match_out <= 1'b0;
    end else begin
      linked_match_out <= link1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      range_couple_out <= 1'b0;
    end else begin
      range_couple_out <= rng1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      debugState <= 1'b0;
    end else if (enterDebug) begin
      debugState <= 1'b1;
    end else if (debugExit) begin
      debugState <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      interruptsDisabled <= 1'b0;
    end else if (enterDebug) begin
      interruptsDisabled <= 1'b1;
    end else if (debugExit) begin
      interruptsDisabled <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irqRemembered <= 1'b0;
    end else if (enterDebug) begin
      irqRemembered <= irqPending;
    end else if (debugExit) begin
      irqRemembered <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      abortRemembered <= 1'b0;
    end else if (enterDebug) begin
      abortRemembered <= dataAbort && fetch_or_data_bit;
    end else if (debugExit) begin
      abortRemembered <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      abortModeEntry <= 1'b0;
    end else if (enterDebug) begin
      abortModeEntry <= dataAbort && fetch_or_data_bit;
    end else if (debugExit) begin
      abortModeEntry <= 1'b0;
    end
  end
endmodule

// ==== watchpoint_comparator_unit_assertions.sv ====
// Checker for the watchpoint comparator top ports.
`timescale 1ns/100ps
module watchpoint_comparator_unit_assertions
  import watchpoint_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // TAP pins
  input wire logic tck,
  input wire logic debug_tap_reset_n,
  input wire logic tdo,
  // Core bus and events
  input wire logic busValid,
  input wire logic fetch_or_data_bit,
  input wire logic prefetchAbort,
  input wire logic debugExit,
  // Observed outputs
  input wire logic break_request,
  input wire logic debugState,
  input wire logic interruptsDisabled,
  input wire logic irqRemembered,
  input wire logic abortRemembered,
  input wire logic linked_match_out
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_break_one_cycle:
    assert property (break_request |=> !break_request)
    else $error("break request wider than one cycle");
  a_break_enters_debug:
    assert property (break_request |-> ##[0:1] debugState)
    else $error("break request without debug state");
  a_debug_masks_irq:
    assert property (debugState |-> interruptsDisabled)
    else $error("interrupts enabled in debug state");
  a_exit_restores_irq:
    assert property (debugState && debugExit |=> !interruptsDisabled)
    else $error("interrupts still off after exit");
  a_abort_beats_break:
    assert property (busValid && prefetchAbort && !fetch_or_data_bit
      && !debugState |=> !break_request)
    else $error("break taken on aborted fetch");
  a_irq_kept_debug:
    assert property (irqRemembered |-> debugState)
    else $error("interrupt flag outside debug state");
  a_abort_kept_debug:
    assert property (abortRemembered |-> debugState)
    else $error("abort flag outside debug state");
  a_tap_reset_unlinks:
    assert property (!debug_tap_reset_n [*6] |-> !linked_match_out)
    else $error("linked output set during tap reset");
  a_tdo_on_fall:
    assert property ($changed(tdo) && debug_tap_reset_n |-> !tck)
    else $error("serial output moved while test clock high");
endmodule

// ==== watchpoint_comparator_unit_tb.sv ====
// Self-checking bench for the watchpoint comparator unit.
`timescale 1ns/100ps
module watchpoint_comparator_unit_tb
  import watchpoint_pkg::*;
;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk, reset, tck, tms, tdi, tapResetN, tdo, busValid, busWrite;
  logic fetchData, privilege, prefetchAbort, dataAbort, irqPending;
  logic debugExit, breakReq, debugState, intsOff, irqRem, abortRem;
  logic abortMode, linkedOut, rangeOut, rngSeen;
  logic [31:0] busAddr, busData, rdVal;
  logic [1:0] busSize, extCond;
  logic [37:0] dummy;
  int nErrors = 0;
  int nCompared = 0;
  int cycles = 0;
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  watchpoint_comparator_unit i_dut (.clk(clk), .reset(reset), .tck(tck),
    .tms(tms), .tdi(tdi), .debug_tap_reset_n(tapResetN), .tdo(tdo),
    .busAddr(busAddr), .busData(busData), .busValid(busValid),
    .busWrite(busWrite), .busSize(busSize), .fetch_or_data_bit(fetchData),
    .privilege_bit(privilege), .external_condition_in(extCond),
    .prefetchAbort(prefetchAbort), .dataAbort(dataAbort),
    .irqPending(irqPending), .debugExit(debugExit),
    .break_request(breakReq), .debugState(debugState),
    .interruptsDisabled(intsOff), .irqRemembered(irqRem),
    .abortRemembered(abortRem), .abortModeEntry(abortMode),
    .linked_match_out(linkedOut), .range_couple_out(rangeOut));
  jtag_debugger_model i_dbg (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrapUp();
    if (nErrors == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    i_dbg.scan({1'h1, a, d}, dummy);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    i_dbg.scan({1'h0, a, 32'hDEADBEEF}, dummy);
    i_dbg.scan({1'h0, a, 32'h0}, dummy);
    q = dummy[31:0];
  endtask
  // One bus cycle with held events, then the break and flag checks.
  task automatic go(input logic [31:0] a, d, input logic fd, w,
    input logic [1:0] sz, input logic [2:0] ex, input logic expB);
    logic got;
    @(posedge clk) #1 {busAddr, busData, fetchData, busWrite} = {a, d, fd, w};
    busSize = sz;
    {prefetchAbort, dataAbort, irqPending} = ex;
    busValid = 1'h1;
    @(posedge clk) #1 busValid = 1'h0;
    got = breakReq;
    rngSeen = rangeOut;
    repeat (4) @(posedge clk) #1 got = got | breakReq;
    {prefetchAbort, dataAbort, irqPending} = 3'h0;
    check({31'h0, got}, {31'h0, expB});
    check({27'h0, debugState, intsOff, irqRem, abortRem, abortMode},
      {27'h0, expB, expB, ex[0] & expB, {2{ex[1] & expB}}});
    if (debugState === 1'h1) begin
      debugExit = 1'h1;
      @(posedge clk) #1 debugExit = 1'h0;
      repeat (2) @(posedge clk) #1;
    end
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    {reset, tapResetN, busValid, debugExit, privilege} = 5'h18;
    {busAddr, busData, busWrite, busSize, fetchData, extCond} = 70'h0;
    {prefetchAbort, dataAbort, irqPending} = 3'h0;
    repeat (12) @(posedge clk);
    #1 reset = 1'h0;
    repeat (3) @(posedge clk) #1;
    rd(5'h14, rdVal);
    check(rdVal & 32'h1FF, 32'h0);
    rd(5'h15, rdVal);
    check(rdVal & 32'hFF, 32'hFF);
    rd(5'h11, rdVal);
    check(rdVal, 32'hFFFFFFFF);
    wr(5'h1A, 32'h5A5AC3C3);
    wr(5'h0A, 32'hFFFFFFFF);
    rd(5'h1A, rdVal);
    check(rdVal, 32'h5A5AC3C3);
    rd(5'h12, rdVal);
    check(rdVal, 32'h0);
    wr(5'h10, 32'h1000);
    wr(5'h11, 32'h3);
    wr(5'h14, 32'h100);
    wr(5'h15, 32'hF7);
    go(32'h1002, 32'h0, 1'h0, 1'h0, 2'h2, 3'h0, 1'h1);
    go(32'h1004, 32'h0, 1'h0, 1'h0, 2'h2, 3'h0, 1'h0);
    go(32'h1000, 32'h0, 1'h1, 1'h0, 2'h2, 3'h0, 1'h0);
    go(32'h1000, 32'h0, 1'h0, 1'h0, 2'h2, 3'h4, 1'h0);
    go(32'h1000, 32'h0, 1'h0, 1'h0, 2'h2, 3'h1, 1'h1);
    wr(5'h15, 32'hFF);
    go(32'h1000, 32'h0, 1'h1, 1'h0, 2'h2, 3'h2, 1'h1);
    wr(5'h14, 32'h0);
    go(32'h1000, 32'h0, 1'h0, 1'h0, 2'h2, 3'h0, 1'h0);
    wr(5'h15, 32'hF0);
    for (int s = 0; s < 3; s++) begin
      wr(5'h14, 32'h109 | 32'(s << 1));
      go(32'h1000, 32'h0, 1'h1, 1'h1, 2'(s), 3'h0, 1'h1);
      go(32'h1000, 32'h0, 1'h1, 1'h0, 2'(s), 3'h0, 1'h0);
      go(32'h1000, 32'h0, 1'h1, 1'h1, 2'((s + 1) % 3), 3'h0, 1'h0);
    end
    wr(5'h14, 32'h0);
    wr(5'h18, 32'h2000);
    wr(5'h19, 32'h0);
    wr(5'h1D, 32'hDF);
    wr(5'h1C, 32'h120);
    extCond = 2'h1;
    go(32'h2000, 32'h0, 1'h0, 1'h0, 2'h2, 3'h0, 1'h0);
    extCond = 2'h2;
    go(32'h2000, 32'h0, 1'h0, 1'h0, 2'h2, 3'h0, 1'h1);
    wr(5'h1B, 32'h0);
    wr(5'h1C, 32'h20);
    go(32'h2000, 32'h5A5AC3C3, 1'h0, 1'h0, 2'h2, 3'h0, 1'h0);
    check({31'h0, linkedOut}, 32'h1);
    go(32'h2000, 32'h0, 1'h0, 1'h0, 2'h2, 3'h0, 1'h0);
    check({31'h0, linkedOut}, 32'h0);
    wr(5'h10, 32'h2000);
    wr(5'h15, 32'h7F);
    wr(5'h14, 32'h180);
    go(32'h2000, 32'h0, 1'h0, 1'h0, 2'h2, 3'h0, 1'h0);
    check({31'h0, rngSeen}, 32'h0);
    go(32'h2000, 32'h5A5AC3C3, 1'h0, 1'h0, 2'h2, 3'h0, 1'h1);
    check({31'h0, rngSeen}, 32'h1);
    wr(5'h15, 32'hBF);
    wr(5'h14, 32'h140);
    go(32'h2000, 32'h0, 1'h0, 1'h0, 2'h2, 3'h0, 1'h1);
    go(32'h2000, 32'h0, 1'h0, 1'h0, 2'h2, 3'h0, 1'h0);
    wr(5'h14, 32'h0);
    go(32'h2000, 32'h5A5AC3C3, 1'h0, 1'h0, 2'h2, 3'h0, 1'h0);
    wr(5'h1C, 32'h20);
    check({31'h0, linkedOut}, 32'h0);
    go(32'h2000, 32'h5A5AC3C3, 1'h0, 1'h0, 2'h2, 3'h0, 1'h0);
    tapResetN = 1'h0;
    repeat (10) @(posedge clk);
    check({31'h0, linkedOut}, 32'h0);
    #1 tapResetN = 1'h1;
    rd(5'h18, rdVal);
    check(rdVal, 32'h2000);
    wrapUp();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 30000) begin
      nErrors++;
      wrapUp();
    end
  end
endmodule
bind watchpoint_comparator_unit watchpoint_comparator_unit_assertions i_chk (
  .clk(clk), .reset(reset), .tck(tck), .debug_tap_reset_n(debug_tap_reset_n),
  .tdo(tdo), .busValid(busValid), .fetch_or_data_bit(fetch_or_data_bit),
  .prefetchAbort(prefetchAbort), .debugExit(debugExit),
  .break_request(break_request), .debugState(debugState),
  .interruptsDisabled(interruptsDisabled), .irqRemembered(irqRemembered),
  .abortRemembered(abortRemembered), .linked_match_out(linked_match_out));

// ==== watchpoint_pkg.sv ====
// Types for the watchpoint comparator unit.
package watchpoint_pkg;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SELDR, TAP_CAPDR, TAP_SHDR, TAP_EX1DR,
    TAP_PAUSEDR, TAP_EX2DR, TAP_UPDDR, TAP_SELIR, TAP_CAPIR, TAP_SHIR,
    TAP_EX1IR, TAP_PAUSEIR, TAP_EX2IR, TAP_UPDIR
  } tap_state_e;
  typedef logic [31:0] word_t;
endpackage

// ==== watchpoint_regs.svh ====
// Constants for the watchpoint comparator unit.
`ifndef WATCHPOINT_REGS_SVH
`define WATCHPOINT_REGS_SVH
// ****************************************************************
// Scan chain layout
// ****************************************************************
`define WP_CHAIN_LEN 38
`define WP_DATA_LSB 0
`define WP_DATA_MSB 31
`define WP_ADDR_LSB 32
`define WP_ADDR_MSB 36
`define WP_RW_BIT 37
// ****************************************************************
// Register addresses (unit 1 adds 8)
// ****************************************************************
`define WP_UNIT_STRIDE 5'h08
`define WP_ADDR_VAL 5'h10
`define WP_ADDR_MSK 5'h11
`define WP_DATA_VAL 5'h12
`define WP_DATA_MSK 5'h13
`define WP_CTRL_VAL 5'h14
`define WP_CTRL_MSK 5'h15
// ****************************************************************
// Control field positions
// ****************************************************************
`define WP_CTL_WRITE 0
`define WP_CTL_SIZE_LSB 1
`define WP_CTL_SIZE_MSB 2
`define WP_CTL_FETCHDATA 3
`define WP_CTL_PRIV 4
`define WP_CTL_EXT 5
`define WP_CTL_CHAIN 6
`define WP_CTL_RANGE 7
`define WP_CTL_ENABLE 8
// ****************************************************************
// Reset values
// ****************************************************************
`define WP_RST_VAL32 32'h00000000
`define WP_RST_MSK32 32'hFFFFFFFF
`define WP_RST_CTRL_VAL 9'h000
`define WP_RST_CTRL_MSK 8'hFF
`endif

// ==== watchpoint_unit.sv ====
// One watchpoint comparator unit with its value and mask registers.
`timescale 1ns/100ps
`include "watchpoint_regs.svh"
module watchpoint_unit
  import watchpoint_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic tapResetHeld,
  // Register access
  input wire logic regWrite,
  input wire logic [2:0] regSel,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  // Bus observation
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busData,
  input wire logic busValid,
  input wire logic [8:0] busCtrl,
  // Coupling
  output logic matchPulse,
  output logic linkedMatchOut,
  output logic rangeCoupleOut
);
  word_t addrVal_reg, addrMsk_reg, dataVal_reg, dataMsk_reg;
  logic [8:0] ctrlVal_reg;
  logic [7:0] ctrlMsk_reg;
  logic addrCtlHit, dataHit;

  // Masked equality: a set mask bit always matches.
  function automatic logic masked_eq(input word_t obs, input word_t val,
                                     input word_t msk);
    masked_eq = &(~(obs ^ val) | msk);
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      addrVal_reg <= `WP_RST_VAL32;
      addrMsk_reg <= `WP_RST_MSK32;
      dataVal_reg <= `WP_RST_VAL32;
      dataMsk_reg <= `WP_RST_MSK32;
      ctrlVal_reg <= `WP_RST_CTRL_VAL;
      ctrlMsk_reg <= `WP_RST_CTRL_MSK;
    end else if (regWrite) begin
      case (regSel)
        3'h0: addrVal_reg <= regWdata;
        3'h1: addrMsk_reg <= regWdata;
        3'h2: dataVal_reg <= regWdata;
        3'h3: dataMsk_reg <= regWdata;
        3'h4: ctrlVal_reg <= regWdata[8:0];
        3'h5: ctrlMsk_reg <= regWdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (regSel)
      3'h0: regRdata = addrVal_reg;
      3'h1: regRdata = addrMsk_reg;
      3'h2: regRdata = dataVal_reg;
      3'h3: regRdata = dataMsk_reg;
      3'h4: regRdata = {23'h000000, ctrlVal_reg};
      3'h5: regRdata = {24'h000000, ctrlMsk_reg};
      default: regRdata = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // Comparators
  // ****************************************************************
  // Enable bit has no mask and is excluded from the masked compare.
  assign addrCtlHit = masked_eq(busAddr, addrVal_reg, addrMsk_reg) &&
    masked_eq({24'h000000, busCtrl[7:0]}, {24'h000000, ctrlVal_reg[7:0]},
              {24'hFFFFFF, ctrlMsk_reg}) && busValid;
  assign dataHit = masked_eq(busData, dataVal_reg, dataMsk_reg);
  assign matchPulse = addrCtlHit && dataHit &&
    ctrlVal_reg[`WP_CTL_ENABLE];
  assign rangeCoupleOut = addrCtlHit && dataHit;

  always_ff @(posedge clk) begin
    if (reset || tapResetHeld) begin
      linkedMatchOut <= 1'b0;
    end else if (regWrite && regSel == 3'h4) begin
      linkedMatchOut <= 1'b0;
    end else if (addrCtlHit) begin
      linkedMatchOut <= dataHit;
    end
  end
endmodule
